//--- shared/mest_pkg.sv
// Constants and types for the motor estimator status register bank
package mest_pkg;
  localparam int DATA_W = 32;
  localparam int STEP_W = 16;
  localparam int ADDR_W = 16;
  localparam int N_SLOTS = 8;
  localparam int CTRL_W = 2;
  // Values are signed fixed point with this many fraction bits
  localparam int FRAC_BITS = 27;

  // Register indices; the byte address is four times the index
  localparam logic [13:0] IDX_SPIN_STEP = 14'h0680;
  localparam logic [13:0] IDX_SPIN_SPEED = 14'h068a;
  localparam logic [13:0] IDX_POS_STEP = 14'h06be;
  localparam logic [13:0] IDX_POS_ANGLE = 14'h0702;
  localparam logic [13:0] IDX_BEMF_D = 14'h0748;
  localparam logic [13:0] IDX_BEMF_Q = 14'h074a;
  localparam logic [13:0] IDX_SPEED_EST = 14'h0758;
  localparam logic [13:0] IDX_ANGLE_EST = 14'h075c;
  localparam logic [13:0] IDX_CTRL = 14'h0760;
  localparam logic [13:0] IDX_UPDATED = 14'h0762;

  // Slot numbers of the captured values
  localparam int SLOT_SPIN_STEP = 0;
  localparam int SLOT_SPIN_SPEED = 1;
  localparam int SLOT_POS_STEP = 2;
  localparam int SLOT_POS_ANGLE = 3;
  localparam int SLOT_BEMF_D = 4;
  localparam int SLOT_BEMF_Q = 5;
  localparam int SLOT_SPEED_EST = 6;
  localparam int SLOT_ANGLE_EST = 7;

  // Spin detection step codes
  localparam logic [STEP_W-1:0] SPIN_INIT = 16'h0000;
  localparam logic [STEP_W-1:0] SPIN_STOP_CHECK = 16'h0001;
  localparam logic [STEP_W-1:0] SPIN_ESTIM_INIT = 16'h0002;
  localparam logic [STEP_W-1:0] SPIN_RUN_CHECK = 16'h0003;
  localparam logic [STEP_W-1:0] SPIN_DIR_CHECK = 16'h0004;
  localparam logic [STEP_W-1:0] SPIN_COMPLETE = 16'h0005;
  localparam logic [STEP_W-1:0] SPIN_FAULT = 16'h0006;

  // Position detection step codes, init 0 through fault 12
  localparam logic [STEP_W-1:0] POS_INIT = 16'h0000;
  localparam logic [STEP_W-1:0] POS_COMPLETE = 16'h000b;
  localparam logic [STEP_W-1:0] POS_FAULT = 16'h000c;

  // Reset values
  localparam logic [STEP_W-1:0] RST_STEP = 16'h0000;
  localparam logic [DATA_W-1:0] RST_VALUE = 32'h00000000;
  localparam logic [CTRL_W-1:0] RST_CTRL = 2'h0;

  // Control register fields
  localparam int CTRL_FREEZE_DET_BIT = 0;
  localparam int CTRL_FREEZE_EST_BIT = 1;

  typedef enum logic {APB_IDLE, APB_ACCESS} apb_state_type;
endpackage

//--- shared/capture_if.sv
// Load strobe, data and held value of one status capture register
`timescale 1ns/1ps
interface capture_if #(parameter int W = 32) ();
  logic load;
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport feed (output load, output d, input q);
  modport hold (input load, input d, output q);
endinterface

//--- rtl/status_capture.sv
// One read-only status register loaded by its producer's strobe
`timescale 1ns/1ps
module status_capture
  import mest_pkg::*;
#(
  parameter int W = 32,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Capture channel
  capture_if.hold cap
);
  logic [W-1:0] value_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= RESET_VALUE;
    end else if (cap.load) begin
      value_ff <= cap.d;
    end
  end

  assign cap.q = value_ff;
endmodule

//--- rtl/motor_estimator_status_regs.sv
// Read-only status register bank of the motor estimator, APB slave
// Behaviour
// - Spin detection step reads as 16-bit code 0 to 6, fault 6.
// - Position detection step reads as 16-bit code 0 to 12, fault 12.
// - Spin detection speed reads as 32-bit fraction of maximum speed.
// - Position detection angle reads as 32-bit fraction of 360 degrees.
// - Estimated direct back-EMF reads as 32-bit scaled value.
// - Estimated quadrature back-EMF reads as 32-bit scaled value.
// - Estimated rotor speed reads as 32-bit fraction of maximum speed.
// - Estimated rotor angle reads as 32-bit fraction of 360 degrees.
// - Reset clears the step codes and all estimator values to zero.
`timescale 1ns/1ps
module motor_estimator_status_regs
  import mest_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Spin detection producer
  input wire logic [STEP_W-1:0] spin_detect_step,
  input wire logic spin_detect_step_load,
  input wire logic [DATA_W-1:0] spin_detect_speed,
  input wire logic spin_detect_speed_load,
  // Position detection producer
  input wire logic [STEP_W-1:0] position_detect_step,
  input wire logic position_detect_step_load,
  input wire logic [DATA_W-1:0] position_detect_angle,
  input wire logic position_detect_angle_load,
  // Estimator producer, one strobe for the whole set
  input wire logic [DATA_W-1:0] backemf_direct_est,
  input wire logic [DATA_W-1:0] backemf_quadrature_est,
  input wire logic [DATA_W-1:0] rotor_speed_est,
  input wire logic [DATA_W-1:0] rotor_angle_est,
  input wire logic estimator_load
);
  // APB phase tracking
  apb_state_type state_ff;
  apb_state_type nxt_state;

  // Control and flags
  logic [CTRL_W-1:0] ctrl_ff;
  logic [N_SLOTS-1:0] updated_ff;
  logic [N_SLOTS-1:0] nxt_updated;

  // Read path, captured in the setup cycle
  logic [DATA_W-1:0] prdata_ff;
  logic slverr_ff;
  logic slot_hit_ff;
  logic [2:0] slot_ff;
  logic ctrl_hit_ff;

  // Decode of the current address
  logic dec_slot_hit;
  logic [2:0] dec_slot;
  logic dec_ctrl_hit;
  logic dec_updated_hit;
  logic dec_mapped;

  // Producer side
  logic [STEP_W-1:0] spin_code;
  logic [STEP_W-1:0] pos_code;
  logic det_open;
  logic est_open;
  logic [N_SLOTS-1:0] load_vec;
  logic [DATA_W-1:0] d_vec [N_SLOTS];
  logic [DATA_W-1:0] q_vec [N_SLOTS];

  // Handshake terms
  logic setup_phase;
  logic access_done;
  logic read_done;
  logic write_done;

  // Out-of-range step codes would read as a state that does not exist,
  // so they are reported as the fault step instead.
  always_comb begin
    if (spin_detect_step > SPIN_FAULT) begin
      spin_code = SPIN_FAULT;
    end else begin
      spin_code = spin_detect_step;
    end
  end

  always_comb begin
    if (position_detect_step > POS_FAULT) begin
      pos_code = POS_FAULT;
    end else begin
      pos_code = position_detect_step;
    end
  end

  // Freeze bits hold a coherent snapshot while software reads a set
  assign det_open = !ctrl_ff[CTRL_FREEZE_DET_BIT];
  assign est_open = !ctrl_ff[CTRL_FREEZE_EST_BIT];

  always_comb begin
    load_vec = '0;
    load_vec[SLOT_SPIN_STEP] = spin_detect_step_load & det_open;
    load_vec[SLOT_SPIN_SPEED] = spin_detect_speed_load & det_open;
    load_vec[SLOT_POS_STEP] = position_detect_step_load & det_open;
    load_vec[SLOT_POS_ANGLE] = position_detect_angle_load & det_open;
    load_vec[SLOT_BEMF_D] = estimator_load & est_open;
    load_vec[SLOT_BEMF_Q] = estimator_load & est_open;
    load_vec[SLOT_SPEED_EST] = estimator_load & est_open;
    load_vec[SLOT_ANGLE_EST] = estimator_load & est_open;
  end

  always_comb begin
    d_vec[SLOT_SPIN_STEP] = {16'h0000, spin_code};
    d_vec[SLOT_SPIN_SPEED] = spin_detect_speed;
    d_vec[SLOT_POS_STEP] = {16'h0000, pos_code};
    d_vec[SLOT_POS_ANGLE] = position_detect_angle;
    d_vec[SLOT_BEMF_D] = backemf_direct_est;
    d_vec[SLOT_BEMF_Q] = backemf_quadrature_est;
    d_vec[SLOT_SPEED_EST] = rotor_speed_est;
    d_vec[SLOT_ANGLE_EST] = rotor_angle_est;
  end

  // Capture registers, all zero after reset
  genvar gi;
  generate
    for (gi = 0; gi < N_SLOTS; gi++) begin : g_cap
      capture_if #(.W(DATA_W)) cap ();
      assign cap.load = load_vec[gi];
      assign cap.d = d_vec[gi];
      assign q_vec[gi] = cap.q;
      status_capture #(
        .W(DATA_W),
        .RESET_VALUE(RST_VALUE)
      ) u_capture (
        .pclk(pclk),
        .presetn(presetn),
        .cap(cap)
      );
    end
  endgenerate

  // Address decode
  always_comb begin
    dec_slot_hit = 1'b1;
    dec_slot = 3'd0;
    dec_ctrl_hit = 1'b0;
    dec_updated_hit = 1'b0;
    case (paddr)
      {IDX_SPIN_STEP, 2'b00}: dec_slot = 3'(SLOT_SPIN_STEP);
      {IDX_SPIN_SPEED, 2'b00}: dec_slot = 3'(SLOT_SPIN_SPEED);
      {IDX_POS_STEP, 2'b00}: dec_slot = 3'(SLOT_POS_STEP);
      {IDX_POS_ANGLE, 2'b00}: dec_slot = 3'(SLOT_POS_ANGLE);
      {IDX_BEMF_D, 2'b00}: dec_slot = 3'(SLOT_BEMF_D);
      {IDX_BEMF_Q, 2'b00}: dec_slot = 3'(SLOT_BEMF_Q);
      {IDX_SPEED_EST, 2'b00}: dec_slot = 3'(SLOT_SPEED_EST);
      {IDX_ANGLE_EST, 2'b00}: dec_slot = 3'(SLOT_ANGLE_EST);
      {IDX_CTRL, 2'b00}: begin
        dec_slot_hit = 1'b0;
        dec_ctrl_hit = 1'b1;
      end
      {IDX_UPDATED, 2'b00}: begin
        dec_slot_hit = 1'b0;
        dec_updated_hit = 1'b1;
      end
      default: begin
        dec_slot_hit = 1'b0;
      end
    endcase
  end

  assign dec_mapped = dec_slot_hit | dec_ctrl_hit | dec_updated_hit;

  // APB handshake: no wait states, answer in the first access cycle
  assign setup_phase = psel & !penable;
  assign access_done = psel & penable & (state_ff == APB_ACCESS);
  assign read_done = access_done & !pwrite;
  assign write_done = access_done & pwrite;

  always_comb begin
    case (state_ff)
      APB_IDLE: begin
        if (setup_phase) begin
          nxt_state = APB_ACCESS;
        end else begin
          nxt_state = APB_IDLE;
        end
      end
      APB_ACCESS: begin
        if (access_done) begin
          nxt_state = APB_IDLE;
        end else begin
          nxt_state = APB_ACCESS;
        end
      end
      default: begin
        nxt_state = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= APB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Read data and error are taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= RST_VALUE;
      slverr_ff <= 1'b0;
      slot_hit_ff <= 1'b0;
      slot_ff <= 3'd0;
      ctrl_hit_ff <= 1'b0;
    end else if (setup_phase) begin
      slverr_ff <= !dec_mapped;
      slot_hit_ff <= dec_slot_hit;
      slot_ff <= dec_slot;
      ctrl_hit_ff <= dec_ctrl_hit;
      if (pwrite || !dec_mapped) begin
        prdata_ff <= RST_VALUE;
      end else if (dec_slot_hit) begin
        prdata_ff <= q_vec[dec_slot];
      end else if (dec_ctrl_hit) begin
        prdata_ff <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_ff};
      end else begin
        prdata_ff <= {{(DATA_W-N_SLOTS){1'b0}}, updated_ff};
      end
    end
  end

  // Only the control register accepts writes; status writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= RST_CTRL;
    end else if (write_done && ctrl_hit_ff && pstrb[0]) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  // Sticky per-value update flags, cleared by reading that value;
  // a load in the clearing cycle keeps the flag set.
  always_comb begin
    nxt_updated = updated_ff;
    for (int i = 0; i < N_SLOTS; i++) begin
      if (load_vec[i]) begin
        nxt_updated[i] = 1'b1;
      end else if (read_done && slot_hit_ff && (slot_ff == 3'(i))) begin
        nxt_updated[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      updated_ff <= '0;
    end else begin
      updated_ff <= nxt_updated;
    end
  end

  assign pready = psel & penable & (state_ff == APB_ACCESS);
  assign pslverr = pready & slverr_ff;
  assign prdata = prdata_ff;
endmodule

//--- bench/motor_estimator_status_regs_chk.sv
// Readback assertions for the motor estimator status register bank
`timescale 1ns/1ps
module motor_estimator_status_regs_chk
  import mest_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  // Producers
  input wire logic [STEP_W-1:0] spin_detect_step,
  input wire logic spin_detect_step_load,
  input wire logic [DATA_W-1:0] spin_detect_speed,
  input wire logic spin_detect_speed_load,
  input wire logic [STEP_W-1:0] position_detect_step,
  input wire logic position_detect_step_load,
  input wire logic [DATA_W-1:0] position_detect_angle,
  input wire logic position_detect_angle_load,
  input wire logic [DATA_W-1:0] backemf_direct_est,
  input wire logic [DATA_W-1:0] backemf_quadrature_est,
  input wire logic [DATA_W-1:0] rotor_speed_est,
  input wire logic [DATA_W-1:0] rotor_angle_est,
  input wire logic estimator_load
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read setup; a new load at that edge would make the expected value ambiguous
  wire rd = psel && !penable && !pwrite;
  a_spin_step_read:
  assert property (spin_detect_step_load ##1 (rd && paddr == {IDX_SPIN_STEP, 2'b00} &&
    !spin_detect_step_load) |=> prdata == {16'h0, (($past(spin_detect_step, 2) > 16'h6) ?
    16'h6 : $past(spin_detect_step, 2))}) else $error("spin step readback wrong");
  a_pos_step_read:
  assert property (position_detect_step_load ##1 (rd && paddr == {IDX_POS_STEP, 2'b00} &&
    !position_detect_step_load) |=> prdata == {16'h0, (($past(position_detect_step, 2) >
    16'hc) ? 16'hc : $past(position_detect_step, 2))}) else $error("pos step readback wrong");
  a_spin_speed_read:
  assert property (spin_detect_speed_load ##1 (rd && paddr == {IDX_SPIN_SPEED, 2'b00} &&
    !spin_detect_speed_load) |=> prdata == $past(spin_detect_speed, 2))
    else $error("spin speed readback wrong");
  a_pos_angle_read:
  assert property (position_detect_angle_load ##1 (rd && paddr == {IDX_POS_ANGLE, 2'b00} &&
    !position_detect_angle_load) |=> prdata == $past(position_detect_angle, 2))
    else $error("pos angle readback wrong");
  a_bemf_d_read:
  assert property (estimator_load ##1 (rd && paddr == {IDX_BEMF_D, 2'b00} && !estimator_load)
    |=> prdata == $past(backemf_direct_est, 2)) else $error("bemf d readback wrong");
  a_bemf_q_read:
  assert property (estimator_load ##1 (rd && paddr == {IDX_BEMF_Q, 2'b00} && !estimator_load)
    |=> prdata == $past(backemf_quadrature_est, 2)) else $error("bemf q readback wrong");
  a_speed_est_read:
  assert property (estimator_load ##1 (rd && paddr == {IDX_SPEED_EST, 2'b00} &&
    !estimator_load) |=> prdata == $past(rotor_speed_est, 2)) else $error("speed readback wrong");
  a_angle_est_read:
  assert property (estimator_load ##1 (rd && paddr == {IDX_ANGLE_EST, 2'b00} &&
    !estimator_load) |=> prdata == $past(rotor_angle_est, 2)) else $error("angle readback wrong");
endmodule

bind motor_estimator_status_regs motor_estimator_status_regs_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .spin_detect_step, .spin_detect_step_load,
  .spin_detect_speed, .spin_detect_speed_load, .position_detect_step,
  .position_detect_step_load, .position_detect_angle, .position_detect_angle_load,
  .backemf_direct_est, .backemf_quadrature_est, .rotor_speed_est, .rotor_angle_est,
  .estimator_load);

//--- bench/motor_estimator_status_regs_tb.sv
// Self-checking bench for the motor estimator status register bank
`timescale 1ns/1ps
module motor_estimator_status_regs_tb import mest_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [4:0] ld;
  logic [DATA_W-1:0] val [8];
  logic [DATA_W-1:0] m [8];
  logic [DATA_W:0] exq [$];
  logic [13:0] idx [8] = '{IDX_SPIN_STEP, IDX_SPIN_SPEED, IDX_POS_STEP, IDX_POS_ANGLE,
    IDX_BEMF_D, IDX_BEMF_Q, IDX_SPEED_EST, IDX_ANGLE_EST};
  int n_fail, total_checks, cyc, seed;
  logic [DATA_W-1:0] keep1, keep4;

  motor_estimator_status_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .spin_detect_step(val[0][15:0]),
    .spin_detect_step_load(ld[0]), .spin_detect_speed(val[1]), .spin_detect_speed_load(ld[1]),
    .position_detect_step(val[2][15:0]), .position_detect_step_load(ld[2]),
    .position_detect_angle(val[3]), .position_detect_angle_load(ld[3]),
    .backemf_direct_est(val[4]), .backemf_quadrature_est(val[5]), .rotor_speed_est(val[6]),
    .rotor_angle_est(val[7]), .estimator_load(ld[4]));

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [DATA_W:0] seen, input logic [DATA_W:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bus master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [DATA_W:0] e,
    input logic [DATA_W-1:0] wd = '0);
    exq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input int s);
    apb(1'b0, {idx[s], 2'b00}, {1'b0, m[s]});
  endtask

  // One producer pulse; slots 4 to 7 share the estimator strobe
  task automatic put(input int s, input logic [DATA_W-1:0] v);
    val[s] <= v;
    ld[s < 4 ? s : 4] <= 1'b1;
    m[s] = (s == 0 && v[15:0] > 16'h6) ? 32'h6 : (s == 2 && v[15:0] > 16'hc) ? 32'hc :
      (s == 0 || s == 2) ? {16'h0, v[15:0]} : v;
    @(posedge pclk);
    ld <= '0;
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, exq.pop_front());

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    seed = 55;
    {presetn, psel, penable, pwrite, paddr, pwdata, ld} = '0;
    pstrb = 4'hf;
    foreach (val[i]) val[i] = '0;
    foreach (m[i]) m[i] = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int s = 0; s < 8; s++) rd(s);
    for (int i = 0; i < 16; i++) begin
      put(0, i < 14 ? i : $random(seed));
      rd(0);
      put(2, i < 14 ? i : $random(seed));
      rd(2);
    end
    for (int i = 0; i < 6; i++)
      for (int s = 1; s < 8; s++)
        if (s != 2) begin
          put(s, $random(seed));
          rd(s);
        end
    // Writes to status registers must leave them as they were
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, {idx[s], 2'b00}, {1'b0, 32'h0}, $random(seed));
      rd(s);
    end
    // Control write without lane 0 strobe is dropped
    pstrb <= 4'he;
    apb(1'b1, {IDX_CTRL, 2'b00}, 33'h0, 32'h3);
    pstrb <= 4'hf;
    apb(1'b0, {IDX_CTRL, 2'b00}, 33'h0);
    // Frozen groups drop loads and set no flag
    apb(1'b1, {IDX_CTRL, 2'b00}, 33'h0, 32'h3);
    apb(1'b0, {IDX_CTRL, 2'b00}, 33'h3);
    keep1 = m[1];
    keep4 = m[4];
    put(1, $random(seed));
    m[1] = keep1;
    apb(1'b0, {IDX_UPDATED, 2'b00}, 33'h0);
    put(4, $random(seed));
    m[4] = keep4;
    rd(1);
    rd(4);
    apb(1'b0, {IDX_UPDATED, 2'b00}, 33'h0);
    // Open again; flags set by loads, cleared only by reading that value
    apb(1'b1, {IDX_CTRL, 2'b00}, 33'h0, 32'h0);
    put(1, $random(seed));
    @(posedge pclk);
    put(4, $random(seed));
    apb(1'b0, {IDX_UPDATED, 2'b00}, 33'hf2);
    rd(1);
    apb(1'b0, {IDX_UPDATED, 2'b00}, 33'hf0);
    // Reset in mid-run clears captures, control and flags
    apb(1'b1, {IDX_CTRL, 2'b00}, 33'h0, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (m[i]) m[i] = '0;
    @(posedge pclk);
    for (int s = 0; s < 8; s++) rd(s);
    apb(1'b0, {IDX_CTRL, 2'b00}, 33'h0);
    apb(1'b0, {IDX_UPDATED, 2'b00}, 33'h0);
    apb(1'b0, 16'h1000, {1'b1, 32'h0});
    apb(1'b1, 16'h1000, {1'b1, 32'h0});
    repeat (2) @(posedge pclk);
    final_report();
  end
endmodule
